// ---- logic/dtt_duty_gate.sv ----
`timescale 1ns/1ps
`default_nettype none
module dtt_duty_gate
(
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic [dtt_pkg::SLOT_W-1:0] slot_i,
  input  wire logic                       throttle_i,
  input  wire logic [dtt_pkg::DUTY_W-1:0] duty_i,
  output logic                            allow_o
);
  // Grants duty_i slots of every sixteen (all sixteen from 16 up) while throttled, all slots otherwise
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      allow_o <= 1'b1;
    else
      allow_o <= !throttle_i || ({1'b0, slot_i} < duty_i);
  end
endmodule // dtt_duty_gate
`default_nettype wire

// ---- logic/dtt_throttle.sv ----
// How it works
// - Count transfer units moved for each memory row separately.
// - Weight each counted transfer by page hit, miss or empty cycle type.
// - Weighted activity over threshold in a window throttles reads and writes.
// - Low over-temperature input means hot, high means normal.
// - Over-temperature level raises interrupt and/or read throttling as configured.
// - Over-temperature read throttling applies to the whole memory bus alike.
// - Separate software read and write throttle duty settings.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dtt_throttle
(
  input  wire logic                        ref_clk_i,
  input  wire logic                        rstn_i,
  input  wire logic                        xfer_valid_i,
  input  wire logic [dtt_pkg::ROW_W-1:0]   xfer_row_i,
  input  wire logic [1:0]                  xfer_type_i,
  input  wire logic [dtt_pkg::UNIT_W-1:0]  xfer_units_i,
  input  wire logic                        over_temp_in_n_i,
  input  wire logic [dtt_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [dtt_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [dtt_pkg::DATA_W-1:0]  rdata_o,
  output logic                             rd_allow_o,
  output logic                             wr_allow_o,
  output logic                             irq_o
);
  logic                          rst_meta;
  logic                          rst_n;
  logic [dtt_pkg::CTRL_W-1:0]    ctrl;
  logic [dtt_pkg::WIN_W-1:0]     window_len;
  logic [dtt_pkg::ACC_W-1:0]     thresh;
  logic [dtt_pkg::WGT_W-1:0]     wgt_hit;
  logic [dtt_pkg::WGT_W-1:0]     wgt_miss;
  logic [dtt_pkg::WGT_W-1:0]     wgt_empty;
  logic [dtt_pkg::DUTY_W-1:0]    rd_duty;
  logic [dtt_pkg::DUTY_W-1:0]    wr_duty;
  logic [dtt_pkg::EV_W-1:0]      irq_stat;
  logic [dtt_pkg::EV_W-1:0]      irq_mask;
  logic [dtt_pkg::EV_W-1:0]      ev_set;
  logic [dtt_pkg::WIN_W-1:0]     win_cnt;
  logic                          win_end;
  logic                          ot_meta;
  logic                          ot_sync;
  logic                          ot_prev;
  logic                          ot_active;
  logic [dtt_pkg::WGT_W-1:0]     cur_wgt;
  logic [dtt_pkg::ROWS-1:0]      row_over;
  logic                          exceed_any;
  logic                          exceed_q;
  logic                          exceed_seen;
  logic                          hw_active;
  logic                          rd_thr;
  logic                          wr_thr;
  logic [dtt_pkg::SLOT_W-1:0]    slot;
  logic [dtt_pkg::ACC_W-1:0]     row_wacc [dtt_pkg::ROWS];
  logic [dtt_pkg::ACC_W-1:0]     row_raw  [dtt_pkg::ROWS];
  logic [dtt_pkg::DATA_W-1:0]    next_rdata;
  logic                          wr_ctrl;
  logic                          wr_stat;

  // Reset release through two flops
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Two-stage synchroniser for the sensor input
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ot_meta <= 1'b1;
      ot_sync <= 1'b1;
      ot_prev <= 1'b1;
    end
    else
    begin
      ot_meta <= over_temp_in_n_i;
      ot_sync <= ot_meta;
      ot_prev <= ot_sync;
    end
  end

  // Low level is the hot condition, acted on as a level
  assign ot_active = !ot_sync;

  // Software register writes
  assign wr_ctrl = wr_i && (addr_i == dtt_pkg::CTRL_OFS);
  assign wr_stat = wr_i && (addr_i == dtt_pkg::IRQ_STAT_OFS);

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl       <= dtt_pkg::CTRL_RST;
      window_len <= dtt_pkg::WINDOW_RST;
      thresh     <= dtt_pkg::THRESH_RST;
      wgt_hit    <= dtt_pkg::WGT_HIT_RST;
      wgt_miss   <= dtt_pkg::WGT_MISS_RST;
      wgt_empty  <= dtt_pkg::WGT_EMPTY_RST;
      rd_duty    <= dtt_pkg::RD_DUTY_RST;
      wr_duty    <= dtt_pkg::WR_DUTY_RST;
      irq_mask   <= dtt_pkg::EV_RST;
    end
    else if (wr_i)
    begin
      case (addr_i)
        dtt_pkg::CTRL_OFS:     ctrl       <= wdata_i[dtt_pkg::CTRL_W-1:0];
        dtt_pkg::WINDOW_OFS:   window_len <= wdata_i[dtt_pkg::WIN_W-1:0];
        dtt_pkg::THRESH_OFS:   thresh     <= wdata_i[dtt_pkg::ACC_W-1:0];
        dtt_pkg::WEIGHT_OFS:
        begin
          wgt_hit   <= wdata_i[dtt_pkg::WGT_HIT_LSB +: dtt_pkg::WGT_W];
          wgt_miss  <= wdata_i[dtt_pkg::WGT_MISS_LSB +: dtt_pkg::WGT_W];
          wgt_empty <= wdata_i[dtt_pkg::WGT_EMPTY_LSB +: dtt_pkg::WGT_W];
        end
        dtt_pkg::RD_DUTY_OFS:  rd_duty    <= wdata_i[dtt_pkg::DUTY_W-1:0];
        dtt_pkg::WR_DUTY_OFS:  wr_duty    <= wdata_i[dtt_pkg::DUTY_W-1:0];
        dtt_pkg::IRQ_MASK_OFS: irq_mask   <= wdata_i[dtt_pkg::EV_W-1:0];
        default:               ;
      endcase
    end
  end

  // Monitoring window timer; a zero length acts as one cycle
  assign win_end = (win_cnt == '0);

  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      win_cnt <= dtt_pkg::WINDOW_RST;
    else if (win_end)
      win_cnt <= (window_len == '0) ? '0 : window_len - 16'h0001;
    else
      win_cnt <= win_cnt - 16'h0001;
  end

  // Weight for the current transfer by its cycle type
  always_comb
  begin
    case (xfer_type_i)
      dtt_pkg::CYC_HIT:   cur_wgt = wgt_hit;
      dtt_pkg::CYC_MISS:  cur_wgt = wgt_miss;
      dtt_pkg::CYC_EMPTY: cur_wgt = wgt_empty;
      default:            cur_wgt = wgt_miss;
    endcase
  end

  // Per-row raw and weighted accumulators, saturating
  generate
    for (genvar r = 0; r < dtt_pkg::ROWS; r++)
    begin : g_row
      logic [dtt_pkg::ACC_W-1:0] wacc;
      logic [dtt_pkg::ACC_W-1:0] raw;
      logic [dtt_pkg::ACC_W:0]   next_wacc;
      logic [dtt_pkg::ACC_W:0]   next_raw;
      logic                      hit;

      assign hit       = xfer_valid_i && (xfer_row_i == (dtt_pkg::ROW_W)'(r));
      // Both factors widened first so the product keeps every bit
      assign next_wacc = {1'b0, wacc} + (dtt_pkg::ACC_W + 1)'(xfer_units_i) * (dtt_pkg::ACC_W + 1)'(cur_wgt);
      assign next_raw  = {1'b0, raw} + (dtt_pkg::ACC_W + 1)'(xfer_units_i);

      always_ff @(posedge ref_clk_i or negedge rst_n)
      begin
        if (!rst_n)
        begin
          wacc <= '0;
          raw  <= '0;
        end
        else if (win_end)
        begin
          wacc <= '0;
          raw  <= '0;
        end
        else if (hit)
        begin
          wacc <= next_wacc[dtt_pkg::ACC_W] ? '1 : next_wacc[dtt_pkg::ACC_W-1:0];
          raw  <= next_raw[dtt_pkg::ACC_W] ? '1 : next_raw[dtt_pkg::ACC_W-1:0];
        end
      end

      assign row_wacc[r] = wacc;
      assign row_raw[r]  = raw;
      assign row_over[r] = (wacc > thresh);
    end
  endgenerate

  assign exceed_any = |row_over;

  // Hardware throttle: set on exceed, kept through the following window
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exceed_q    <= 1'b0;
      exceed_seen <= 1'b0;
      hw_active   <= 1'b0;
    end
    else
    begin
      exceed_q <= exceed_any;
      if (win_end)
      begin
        exceed_seen <= 1'b0;
        hw_active   <= exceed_seen || exceed_any;
      end
      else if (exceed_any)
      begin
        exceed_seen <= 1'b1;
        hw_active   <= 1'b1;
      end
    end
  end

  // Throttle requests; sensor read throttle covers all rows at once
  assign rd_thr = (ctrl[dtt_pkg::CTRL_HW_EN_BIT] && hw_active)
                || (ctrl[dtt_pkg::CTRL_OT_RD_BIT] && ot_active);
  assign wr_thr = ctrl[dtt_pkg::CTRL_HW_EN_BIT] && hw_active;

  // Free-running slot counter shared by both gates
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      slot <= '0;
    else
      slot <= slot + 4'h1;
  end

  // Read and write gates with independent duty settings
  dtt_duty_gate u_rd_gate
  (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n),
    .slot_i     (slot),
    .throttle_i (rd_thr),
    .duty_i     (rd_duty),
    .allow_o    (rd_allow_o)
  );

  dtt_duty_gate u_wr_gate
  (
    .ref_clk_i  (ref_clk_i),
    .rst_n_i    (rst_n),
    .slot_i     (slot),
    .throttle_i (wr_thr),
    .duty_i     (wr_duty),
    .allow_o    (wr_allow_o)
  );

  // Event sources; hot status re-sets every cycle while the level holds
  always_comb
  begin
    ev_set                         = '0;
    ev_set[dtt_pkg::EV_EXCEED_BIT] = exceed_any && !exceed_q;
    ev_set[dtt_pkg::EV_OT_ON_BIT]  = ot_active;
    ev_set[dtt_pkg::EV_OT_OFF_BIT] = ot_sync && !ot_prev;
  end

  // Sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_stat <= dtt_pkg::EV_RST;
    else if (wr_stat)
      irq_stat <= (irq_stat & ~wdata_i[dtt_pkg::EV_W-1:0]) | ev_set;
    else
      irq_stat <= irq_stat | ev_set;
  end

  // Level interrupt while any unmasked status bit is set
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_stat & irq_mask);
  end

  // Read mux, unmapped addresses read as zero
  always_comb
  begin
    next_rdata = '0;
    case (addr_i)
      dtt_pkg::CTRL_OFS:     next_rdata[dtt_pkg::CTRL_W-1:0] = ctrl;
      dtt_pkg::WINDOW_OFS:   next_rdata[dtt_pkg::WIN_W-1:0]  = window_len;
      dtt_pkg::THRESH_OFS:   next_rdata[dtt_pkg::ACC_W-1:0]  = thresh;
      dtt_pkg::WEIGHT_OFS:
      begin
        next_rdata[dtt_pkg::WGT_HIT_LSB +: dtt_pkg::WGT_W]   = wgt_hit;
        next_rdata[dtt_pkg::WGT_MISS_LSB +: dtt_pkg::WGT_W]  = wgt_miss;
        next_rdata[dtt_pkg::WGT_EMPTY_LSB +: dtt_pkg::WGT_W] = wgt_empty;
      end
      dtt_pkg::RD_DUTY_OFS:  next_rdata[dtt_pkg::DUTY_W-1:0] = rd_duty;
      dtt_pkg::WR_DUTY_OFS:  next_rdata[dtt_pkg::DUTY_W-1:0] = wr_duty;
      dtt_pkg::IRQ_STAT_OFS: next_rdata[dtt_pkg::EV_W-1:0]   = irq_stat;
      dtt_pkg::IRQ_MASK_OFS: next_rdata[dtt_pkg::EV_W-1:0]   = irq_mask;
      dtt_pkg::STATE_OFS:
      begin
        next_rdata[dtt_pkg::ST_OT_BIT]     = ot_active;
        next_rdata[dtt_pkg::ST_HW_BIT]     = hw_active;
        next_rdata[dtt_pkg::ST_RD_THR_BIT] = rd_thr;
        next_rdata[dtt_pkg::ST_WR_THR_BIT] = wr_thr;
      end
      dtt_pkg::ROW_CNT_OFS:
        next_rdata[dtt_pkg::ACC_W-1:0] = row_raw[0];
      dtt_pkg::ROW_CNT_OFS + dtt_pkg::ROW_STEP:
        next_rdata[dtt_pkg::ACC_W-1:0] = row_raw[1];
      dtt_pkg::ROW_CNT_OFS + 8'h08:
        next_rdata[dtt_pkg::ACC_W-1:0] = row_raw[2];
      dtt_pkg::ROW_CNT_OFS + 8'h0C:
        next_rdata[dtt_pkg::ACC_W-1:0] = row_raw[3];
      default:               next_rdata = '0;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      rdata_o <= '0;
    else if (rd_i)
      rdata_o <= next_rdata;
    else
      rdata_o <= '0;
  end

  // Weighted totals are visible only through the threshold comparison
  logic unused_wacc;
  assign unused_wacc = ^row_wacc[0] ^ wr_ctrl;
endmodule // dtt_throttle
`default_nettype wire

// ---- pkg/dtt_pkg.sv ----
`default_nettype none
package dtt_pkg;
  // Bus and datapath widths
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int ROWS    = 4;
  localparam int ROW_W   = 2;
  localparam int UNIT_W  = 3;
  localparam int WGT_W   = 8;
  localparam int ACC_W   = 24;
  localparam int WIN_W   = 16;
  localparam int SLOT_W  = 4;
  localparam int DUTY_W  = 5;
  localparam int EV_W    = 3;
  localparam int CTRL_W  = 2;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS     = 8'h00;
  localparam logic [ADDR_W-1:0] WINDOW_OFS   = 8'h04;
  localparam logic [ADDR_W-1:0] THRESH_OFS   = 8'h08;
  localparam logic [ADDR_W-1:0] WEIGHT_OFS   = 8'h0C;
  localparam logic [ADDR_W-1:0] RD_DUTY_OFS  = 8'h10;
  localparam logic [ADDR_W-1:0] WR_DUTY_OFS  = 8'h14;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h1C;
  localparam logic [ADDR_W-1:0] STATE_OFS    = 8'h20;
  localparam logic [ADDR_W-1:0] ROW_CNT_OFS  = 8'h24;
  localparam logic [ADDR_W-1:0] ROW_STEP     = 8'h04;

  // Control field positions
  localparam int CTRL_HW_EN_BIT = 0;
  localparam int CTRL_OT_RD_BIT = 1;

  // Weight register field positions
  localparam int WGT_HIT_LSB   = 0;
  localparam int WGT_MISS_LSB  = 8;
  localparam int WGT_EMPTY_LSB = 16;

  // Event bit positions in status and mask
  localparam int EV_EXCEED_BIT = 0;
  localparam int EV_OT_ON_BIT  = 1;
  localparam int EV_OT_OFF_BIT = 2;

  // State register field positions
  localparam int ST_OT_BIT    = 0;
  localparam int ST_HW_BIT    = 1;
  localparam int ST_RD_THR_BIT = 2;
  localparam int ST_WR_THR_BIT = 3;

  // Access cycle type encoding
  localparam logic [1:0] CYC_HIT   = 2'h0;
  localparam logic [1:0] CYC_MISS  = 2'h1;
  localparam logic [1:0] CYC_EMPTY = 2'h2;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST    = 2'h0;
  localparam logic [WIN_W-1:0]  WINDOW_RST  = 16'h0400;
  localparam logic [ACC_W-1:0]  THRESH_RST  = 24'h001000;
  localparam logic [WGT_W-1:0]  WGT_HIT_RST   = 8'h02;
  localparam logic [WGT_W-1:0]  WGT_MISS_RST  = 8'h04;
  localparam logic [WGT_W-1:0]  WGT_EMPTY_RST = 8'h03;
  localparam logic [DUTY_W-1:0] RD_DUTY_RST = 5'h08;
  localparam logic [DUTY_W-1:0] WR_DUTY_RST = 5'h08;
  localparam logic [EV_W-1:0]   EV_RST      = 3'h0;
endpackage
`default_nettype wire

// ---- verification/dtt_sensor_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dtt_sensor_model
(
  input  wire logic [1:0] hot_i,
  output logic            ot_n_o
);
  // Open-drain sensors share one line; the pull-up gives high when none is hot
  assign ot_n_o = ~|hot_i;
endmodule // dtt_sensor_model
`default_nettype wire

// ---- verification/dtt_throttle_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module dtt_throttle_monitor
(
  input wire logic        ref_clk_i,
  input wire logic        rstn_i,
  input wire logic        xfer_valid_i,
  input wire logic        over_temp_in_n_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        rd_allow_o,
  input wire logic        wr_allow_o,
  input wire logic        irq_o
);
  default clocking dc @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // No traffic and a cool sensor long enough for every event to settle
  sequence quiet; (over_temp_in_n_i && !xfer_valid_i)[*6]; endsequence
  sequence hot8; (!over_temp_in_n_i)[*8]; endsequence
  sequence cool8; over_temp_in_n_i[*8]; endsequence
  sequence rd_at(a); rd_i && addr_i == a; endsequence
  // A write followed at once by a read of the same place returns the field
  property p_back(a, m);
    wr_i && addr_i == a ##1 rd_at(a) |=> (rdata_o & m) == ($past(wdata_i, 2) & m);
  endproperty
  AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside its cycle");
  AST_WGT_BACK: assert property (p_back(dtt_pkg::WEIGHT_OFS, 32'h00FFFFFF))
    else $error("weight readback differs");
  AST_THR_BACK: assert property (p_back(dtt_pkg::THRESH_OFS, 32'h00FFFFFF))
    else $error("threshold readback differs");
  AST_RDUTY_BACK: assert property (p_back(dtt_pkg::RD_DUTY_OFS, 32'h0000001F))
    else $error("read duty readback differs");
  AST_WDUTY_BACK: assert property (p_back(dtt_pkg::WR_DUTY_OFS, 32'h0000001F))
    else $error("write duty readback differs");
  AST_OT_HOT: assert property (hot8 ##0 rd_at(dtt_pkg::STATE_OFS) |=> rdata_o[0])
    else $error("low sensor level not shown as hot");
  AST_OT_COOL: assert property (cool8 ##0 rd_at(dtt_pkg::STATE_OFS) |=> !rdata_o[0])
    else $error("high sensor level shown as hot");
  AST_IRQ_CLR: assert property (quiet ##0 (wr_i && addr_i == dtt_pkg::IRQ_STAT_OFS && wdata_i[2:0] == 3'h7)
    |-> ##2 !irq_o)
    else $error("interrupt stays after full clear");
  AST_RST_OUT: assert property ($rose(rstn_i) |-> rd_allow_o && wr_allow_o && !irq_o)
    else $error("outputs not idle at reset release");
endmodule // dtt_throttle_monitor
bind dtt_throttle dtt_throttle_monitor u_mon (.ref_clk_i, .rstn_i, .xfer_valid_i, .over_temp_in_n_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rd_allow_o, .wr_allow_o, .irq_o);
`default_nettype wire

// ---- verification/dtt_throttle_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dtt_throttle_tb;
  logic        ref_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        xfer_valid_i = 1'b0;
  logic [1:0]  xfer_row_i = 2'h0;
  logic [1:0]  xfer_type_i = 2'h0;
  logic [2:0]  xfer_units_i = 3'h0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [1:0]  hot = 2'h0;
  wire logic   ot_n;
  logic [31:0] rdata_o;
  logic        rd_allow_o;
  logic        wr_allow_o;
  logic        irq_o;
  logic [31:0] seed = 32'h000152AA; // Start value 86698
  logic [31:0] got;
  logic [23:0] cnt [4] = '{default: 24'h0};
  logic [7:0]  ofs [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'hFC};
  logic [31:0] rv [10] = '{32'h0, 32'h400, 32'h1000, 32'h030402, 32'h8, 32'h8, 32'h0, 32'h0, 32'h0, 32'h0};
  int          n_fail = 0;
  int          samples_checked = 0;
  int          ones_r;
  int          ones_w;

  // Clock at 125 MHz
  always #4 ref_clk_i = ~ref_clk_i;

  dtt_sensor_model u_sens (.hot_i(hot), .ot_n_o(ot_n));
  dtt_throttle DUT (.ref_clk_i, .rstn_i, .xfer_valid_i, .xfer_row_i, .xfer_type_i, .xfer_units_i,
    .over_temp_in_n_i(ot_n), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .rd_allow_o, .wr_allow_o, .irq_o);

  // Pseudo-random sequence
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Permitted cycles out of sixteen for a duty value
  function automatic int allowed(input logic [4:0] d);
    return (d > 5'h0F) ? 16 : int'(d);
  endfunction

  task automatic end_of_test();
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    @(posedge ref_clk_i);
    d = rdata_o;
  endtask

  // Random write with an immediate read of the same register
  task automatic back(input logic [7:0] a, input logic [31:0] m);
    logic [31:0] v;
    seed = lfsr(seed);
    v = seed;
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    rd(a, got);
    chk(got & m, v & m);
  endtask

  // One transfer on row 1 followed by an idle cycle
  task automatic xf(input logic [1:0] t, input logic [2:0] u);
    xfer_valid_i <= 1'b1;
    xfer_row_i <= 2'h1;
    xfer_type_i <= t;
    xfer_units_i <= u;
    @(posedge ref_clk_i);
    xfer_valid_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic wait_irq(input logic e);
    int i;
    for (i = 0; i < 20 && irq_o !== e; i++)
      @(posedge ref_clk_i);
    chk({31'h0, irq_o}, {31'h0, e});
    if (irq_o !== e)
      end_of_test();
  endtask

  // Count permitted cycles over one slot period
  task automatic duty();
    ones_r = 0;
    ones_w = 0;
    repeat (16)
    begin
      @(posedge ref_clk_i);
      ones_r += (rd_allow_o === 1'b1);
      ones_w += (wr_allow_o === 1'b1);
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (5) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    chk({29'h0, rd_allow_o, wr_allow_o, irq_o}, 32'h6);
    for (int i = 0; i < 10; i++)
    begin
      rd(ofs[i], got);
      chk(got, rv[i]);
    end
    repeat (4)
    begin
      back(8'h0C, 32'h00FFFFFF);
      back(8'h08, 32'h00FFFFFF);
      back(8'h10, 32'h1F);
      back(8'h14, 32'h1F);
    end
    wr(8'h0C, 32'h0);
    wr(8'h08, 32'h00FFFFFF);
    wr(8'h04, 32'h0000FFFF);
    repeat (1100) @(posedge ref_clk_i);
    for (int i = 0; i < 24; i++)
    begin
      seed = lfsr(seed);
      xfer_valid_i <= 1'b1;
      xfer_row_i <= {seed[0], 1'b0};
      xfer_type_i <= seed[5:4];
      xfer_units_i <= seed[10:8];
      cnt[{seed[0], 1'b0}] += 24'(seed[10:8]);
      @(posedge ref_clk_i);
    end
    xfer_valid_i <= 1'b0;
    @(posedge ref_clk_i);
    for (int r = 0; r < 4; r++)
    begin
      rd(8'h24 + 8'(4 * r), got);
      chk(got, {8'h0, cnt[r]});
    end
    // Over-temperature throttles reads only, on the level
    wr(8'h18, 32'h7);
    wr(8'h00, 32'h2);
    wr(8'h10, 32'h0);
    hot <= 2'h1;
    repeat (8) @(posedge ref_clk_i);
    rd(8'h20, got);
    chk(got, 32'h5);
    duty();
    chk({ones_r[15:0], ones_w[15:0]}, {16'(allowed(5'h0)), 16'h10});
    chk({31'h0, irq_o}, 32'h0);
    wr(8'h1C, 32'h6);
    wait_irq(1'b1);
    wr(8'h18, 32'h2);
    rd(8'h18, got);
    chk(got & 32'h2, 32'h2);
    hot <= 2'h2;
    repeat (8) @(posedge ref_clk_i);
    rd(8'h20, got);
    chk(got, 32'h5);
    hot <= 2'h0;
    repeat (8) @(posedge ref_clk_i);
    rd(8'h20, got);
    chk(got, 32'h0);
    rd(8'h18, got);
    chk(got & 32'h4, 32'h4);
    wr(8'h18, 32'h7);
    wait_irq(1'b0);
    // Weighted activity over the threshold throttles both directions
    wr(8'h1C, 32'h1);
    wr(8'h0C, 32'h00001001);
    wr(8'h08, 32'h1F);
    wr(8'h10, 32'h4);
    wr(8'h14, 32'h2);
    wr(8'h00, 32'h1);
    xf(2'h0, 3'h7);
    xf(2'h2, 3'h7);
    repeat (4) @(posedge ref_clk_i);
    rd(8'h20, got);
    chk(got, 32'h0);
    xf(2'h1, 3'h2);
    repeat (4) @(posedge ref_clk_i);
    rd(8'h20, got);
    chk(got, 32'hE);
    wait_irq(1'b1);
    duty();
    chk({ones_r[15:0], ones_w[15:0]}, {16'(allowed(5'h4)), 16'(allowed(5'h2))});
    wr(8'h18, 32'h1);
    wait_irq(1'b0);
    end_of_test();
  end
endmodule // dtt_throttle_tb
`default_nettype wire
